/* File: hdl/irq_router_24src_4dst.sv */
// Purpose: 24-source, 4-destination interrupt router with APB registers
// Assumes: peripheral and module inputs are on core_clk; pin inputs are not
// Notes: zero-wait APB, read data captured in the setup cycle
`timescale 1ns/1ps
module irq_router_24src_4dst #(
  parameter int NUM_MOD = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb slave
  input irq_router_pkg::apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt sources: peripherals on bits 3..23, modules, pins
  input wire logic [irq_router_pkg::NUM_SRC-1:3] periph_irq,
  input wire logic [NUM_MOD-1:0] module_irq,
  input wire logic pin_source_zero,
  input wire logic pin_source_one,
  // destinations
  output logic [1:0] cpu_irq,
  output logic [1:0] pcie_irq_req,
  output logic [1:0] pin_irq_out,
  output logic [1:0] pin_irq_oe
);
  import irq_router_pkg::*;

  // edge or level detection shared by sources and modules
  function automatic logic detect(input logic [1:0] kind, input logic cur,
                                  input logic prev);
    logic r;
    r = 1'b0;
    case (kind)
      KIND_LEVEL: r = cur;
      KIND_ANY: r = cur ^ prev;
      KIND_FALL: r = prev & ~cur;
      default: r = cur & ~prev;
    endcase
    return r;
  endfunction

  // address match of a completed access
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  // byte address of one replicated destination word, shared by writes and reads
  function automatic logic [ADDR_W-1:0] tgt_word(input logic [ADDR_W-1:0] base,
                                                input int idx);
    return base + ADDR_W'(idx) * DST_STRIDE;
  endfunction

  logic acc;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wd;
  assign acc = apb_req.psel & apb_req.penable;
  assign wr = acc & apb_req.pwrite;
  assign addr = apb_req.paddr;
  assign wd = apb_req.pwdata;

  // configuration registers
  logic [NUM_SRC-1:0] src_nonlatch_sel;
  logic [2*NUM_SRC-1:0] src_detect_kind;
  logic [NUM_SRC-1:0] src_event_log;
  logic [NUM_SRC-1:0] src_enable_mask;
  logic [NUM_SRC-1:0] target_source_mask [NUM_DST];
  logic [NUM_MOD-1:0] module_polarity;
  logic [NUM_MOD-1:0] module_nonlatch_sel;
  logic [2*NUM_MOD-1:0] module_detect_kind;
  logic [NUM_MOD-1:0] module_event_log;
  logic [NUM_MOD-1:0] module_enable_mask;
  logic [1:0] pin_input_polarity;
  logic [1:0] pin_output_polarity;
  logic [1:0] pin_output_drive_sel;

  // datapath
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic [NUM_MOD-1:0] module_level_view;
  logic [NUM_MOD-1:0] module_prev_reg;
  logic [NUM_MOD-1:0] module_hit;
  logic [NUM_MOD-1:0] module_active_view;
  logic [NUM_SRC-1:0] src_level_view;
  logic [NUM_SRC-1:0] src_prev_reg;
  logic [NUM_SRC-1:0] src_hit;
  logic [NUM_SRC-1:0] src_active_view;
  logic [NUM_SRC-1:0] src_inject;
  logic [NUM_SRC-1:0] target_active_view [NUM_DST];
  logic [NUM_DST-1:0] target_irq;

  // pin inputs cross in through two flops before anything reads them
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
    end else begin
      pin_meta_reg <= {pin_source_one, pin_source_zero};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // module hierarchy: polarity first, so the core sees active high
  assign module_level_view = module_irq ^ module_polarity;

  genvar gm;
  generate
    for (gm = 0; gm < NUM_MOD; gm++) begin : g_mod
      assign module_hit[gm] = detect(module_detect_kind[2*gm +: 2],
                                     module_level_view[gm], module_prev_reg[gm]);
      // bypass hands the polarity-corrected level straight on
      assign module_active_view[gm] = module_enable_mask[gm] &
        (module_nonlatch_sel[gm] ? module_level_view[gm] : module_event_log[gm]);
    end
  endgenerate

  // source vector in its fixed bit order
  assign src_level_view[SRC_MODULE_AGG] = |module_active_view;
  assign src_level_view[SRC_PIN_ZERO] = pin_sync_reg[0] ^ pin_input_polarity[0];
  assign src_level_view[SRC_PIN_ONE] = pin_sync_reg[1] ^ pin_input_polarity[1];
  assign src_level_view[NUM_SRC-1:SRC_PERIPH_LO] = periph_irq;

  // inject is write-only: a write of ones lands in the log at that edge
  assign src_inject = (wr && hit(addr, OFF_SRC_INJECT)) ? wd[NUM_SRC-1:0]
                                                       : {NUM_SRC{1'b0}};

  genvar gs;
  generate
    for (gs = 0; gs < NUM_SRC; gs++) begin : g_src
      assign src_hit[gs] = detect(src_detect_kind[2*gs +: 2],
                                  src_level_view[gs], src_prev_reg[gs]);
      assign src_active_view[gs] = src_enable_mask[gs] &
        (src_nonlatch_sel[gs] ? src_level_view[gs] : src_event_log[gs]);
    end
  endgenerate

  // per-destination masking and or-reduction
  genvar gd;
  generate
    for (gd = 0; gd < NUM_DST; gd++) begin : g_dst
      assign target_active_view[gd] = src_active_view & target_source_mask[gd];
      assign target_irq[gd] = |target_active_view[gd];
    end
  endgenerate

  // previous levels for edge detection
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_prev_reg <= {NUM_SRC{1'b0}};
      module_prev_reg <= {NUM_MOD{1'b0}};
    end else begin
      src_prev_reg <= src_level_view;
      module_prev_reg <= module_level_view;
    end
  end

  // source log: a new event in the clearing cycle wins over the clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_event_log <= RST_CFG[NUM_SRC-1:0];
    end else if (wr && hit(addr, OFF_SRC_LOG)) begin
      src_event_log <= (src_event_log & ~wd[NUM_SRC-1:0]) | src_hit | src_inject;
    end else begin
      src_event_log <= src_event_log | src_hit | src_inject;
    end
  end

  // module log, same clearing scheme
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      module_event_log <= RST_CFG[NUM_MOD-1:0];
    end else if (wr && hit(addr, OFF_MOD_LOG)) begin
      module_event_log <= (module_event_log & ~wd[NUM_MOD-1:0]) | module_hit;
    end else begin
      module_event_log <= module_event_log | module_hit;
    end
  end

  // source enable with plain, clear and set aliases
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_enable_mask <= RST_CFG[NUM_SRC-1:0];
    end else if (wr && hit(addr, OFF_SRC_ENA)) begin
      src_enable_mask <= wd[NUM_SRC-1:0];
    end else if (wr && hit(addr, OFF_SRC_ENA_CLR)) begin
      src_enable_mask <= src_enable_mask & ~wd[NUM_SRC-1:0];
    end else if (wr && hit(addr, OFF_SRC_ENA_SET)) begin
      src_enable_mask <= src_enable_mask | wd[NUM_SRC-1:0];
    end
  end

  // source bypass select
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_nonlatch_sel <= RST_CFG[NUM_SRC-1:0];
    end else if (wr && hit(addr, OFF_SRC_NONLATCH)) begin
      src_nonlatch_sel <= wd[NUM_SRC-1:0];
    end
  end

  // detect kinds span two words: sources 0..15 low, the rest high
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_detect_kind <= {RST_CFG[15:0], RST_CFG};
    end else if (wr && hit(addr, OFF_SRC_KIND_LO)) begin
      src_detect_kind[31:0] <= wd;
    end else if (wr && hit(addr, OFF_SRC_KIND_HI)) begin
      src_detect_kind[2*NUM_SRC-1:32] <= wd[2*NUM_SRC-33:0];
    end
  end

  // destination masks, one word each
  genvar gw;
  generate
    for (gw = 0; gw < NUM_DST; gw++) begin : g_map
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          target_source_mask[gw] <= RST_MAP[NUM_SRC-1:0];
        end else if (wr && hit(addr, tgt_word(OFF_TGT_MASK0, gw))) begin
          target_source_mask[gw] <= wd[NUM_SRC-1:0];
        end
      end
    end
  endgenerate

  // module polarity; changing it on a steady line looks like an edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      module_polarity <= RST_CFG[NUM_MOD-1:0];
    end else if (wr && hit(addr, OFF_MOD_POL)) begin
      module_polarity <= wd[NUM_MOD-1:0];
    end
  end

  // module bypass select
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      module_nonlatch_sel <= RST_CFG[NUM_MOD-1:0];
    end else if (wr && hit(addr, OFF_MOD_NONLATCH)) begin
      module_nonlatch_sel <= wd[NUM_MOD-1:0];
    end
  end

  // module detect kinds, two bits per module, one word for up to 16 modules
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      module_detect_kind <= RST_CFG[2*NUM_MOD-1:0];
    end else if (wr && hit(addr, OFF_MOD_KIND)) begin
      module_detect_kind <= wd[2*NUM_MOD-1:0];
    end
  end

  // module enable; this level has no set or clear aliases
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      module_enable_mask <= RST_CFG[NUM_MOD-1:0];
    end else if (wr && hit(addr, OFF_MOD_ENA)) begin
      module_enable_mask <= wd[NUM_MOD-1:0];
    end
  end

  // pin input polarity, applied after the synchroniser
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_input_polarity <= RST_CFG[1:0];
    end else if (wr && hit(addr, OFF_PIN_IN_POL)) begin
      pin_input_polarity <= wd[1:0];
    end
  end

  // pin output polarity
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_output_polarity <= RST_CFG[1:0];
    end else if (wr && hit(addr, OFF_PIN_OUT_POL)) begin
      pin_output_polarity <= wd[1:0];
    end
  end

  // pin drive mode
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_output_drive_sel <= RST_CFG[1:0];
    end else if (wr && hit(addr, OFF_PIN_DRV)) begin
      pin_output_drive_sel <= wd[1:0];
    end
  end

  // cpu and in-band destinations registered so they never glitch
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_irq <= 2'h0;
      pcie_irq_req <= 2'h0;
    end else begin
      cpu_irq <= target_irq[1:0];
      pcie_irq_req <= target_irq[3:2];
    end
  end

  // external pins: polarity only after routing; oe is low in reset and, in drive 1, while not asserted
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_irq_out <= 2'h0;
      pin_irq_oe <= 2'h0;
    end else begin
      for (int e = 0; e < 2; e++) begin
        // drive 0: push both levels; drive 1: only drive when asserted
        pin_irq_out[e] <= pin_output_drive_sel[e] ? ~pin_output_polarity[e]
                                                  : target_irq[2+e] ^ pin_output_polarity[e];
        pin_irq_oe[e] <= pin_output_drive_sel[e] ? target_irq[2+e] : 1'b1;
      end
    end
  end

  // read mux, also flags unmapped offsets
  logic [31:0] rd_val;
  logic rd_err;
  always_comb begin
    rd_val = 32'h0;
    rd_err = 1'b0;
    case (addr)
      OFF_SRC_LEVEL: rd_val[NUM_SRC-1:0] = src_level_view;
      OFF_SRC_NONLATCH: rd_val[NUM_SRC-1:0] = src_nonlatch_sel;
      OFF_SRC_KIND_LO: rd_val = src_detect_kind[31:0];
      OFF_SRC_KIND_HI: rd_val[2*NUM_SRC-33:0] = src_detect_kind[2*NUM_SRC-1:32];
      OFF_SRC_INJECT: rd_val = 32'h0;
      OFF_SRC_LOG: rd_val[NUM_SRC-1:0] = src_event_log;
      OFF_SRC_ENA, OFF_SRC_ENA_CLR, OFF_SRC_ENA_SET: rd_val[NUM_SRC-1:0] = src_enable_mask;
      OFF_SRC_ACTIVE: rd_val[NUM_SRC-1:0] = src_active_view;
      OFF_MOD_POL: rd_val[NUM_MOD-1:0] = module_polarity;
      OFF_MOD_LEVEL: rd_val[NUM_MOD-1:0] = module_level_view;
      OFF_MOD_NONLATCH: rd_val[NUM_MOD-1:0] = module_nonlatch_sel;
      OFF_MOD_KIND: rd_val[2*NUM_MOD-1:0] = module_detect_kind;
      OFF_MOD_LOG: rd_val[NUM_MOD-1:0] = module_event_log;
      OFF_MOD_ENA: rd_val[NUM_MOD-1:0] = module_enable_mask;
      OFF_MOD_ACTIVE: rd_val[NUM_MOD-1:0] = module_active_view;
      OFF_PIN_IN_POL: rd_val[1:0] = pin_input_polarity;
      OFF_PIN_OUT_POL: rd_val[1:0] = pin_output_polarity;
      OFF_PIN_DRV: rd_val[1:0] = pin_output_drive_sel;
      default: rd_err = 1'b1;
    endcase
    // replicated destination words
    for (int d = 0; d < NUM_DST; d++) begin
      if (addr == tgt_word(OFF_TGT_MASK0, d)) begin
        rd_val = {{(32-NUM_SRC){1'b0}}, target_source_mask[d]};
        rd_err = 1'b0;
      end
      if (addr == tgt_word(OFF_TGT_ACTIVE0, d)) begin
        rd_val = {{(32-NUM_SRC){1'b0}}, target_active_view[d]};
        rd_err = 1'b0;
      end
    end
  end

  // capture in setup so the access phase completes without wait states
  logic err_reg;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0;
    end else if (apb_req.psel && !apb_req.penable) begin
      prdata <= apb_req.pwrite ? 32'h0 : rd_val;
    end
  end

  // unmapped flag rides the same capture, so pslverr is ready at the access edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      err_reg <= 1'b0;
    end else if (apb_req.psel && !apb_req.penable) begin
      err_reg <= rd_err;
    end
  end

  assign pready = 1'b1;
  assign pslverr = acc & err_reg;
endmodule

/* File: shared/irq_router_pkg.sv */
// Purpose: constants and carrier types for the interrupt router
// Assumes: APB slave, 32-bit data, one word per register
// Notes: all event signals inside the router are active high
package irq_router_pkg;
  localparam int NUM_SRC = 24;
  localparam int NUM_DST = 4;
  localparam int ADDR_W = 12;
  // source bit positions
  localparam int SRC_MODULE_AGG = 0;
  localparam int SRC_PIN_ZERO = 1;
  localparam int SRC_PIN_ONE = 2;
  localparam int SRC_PERIPH_LO = 3;
  // detect kinds
  localparam logic [1:0] KIND_LEVEL = 2'h0;
  localparam logic [1:0] KIND_ANY = 2'h1;
  localparam logic [1:0] KIND_FALL = 2'h2;
  localparam logic [1:0] KIND_RISE = 2'h3;
  // reset values
  localparam logic [31:0] RST_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_MAP = 32'h0000_0000;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_SRC_LEVEL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_SRC_NONLATCH = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_SRC_KIND_LO = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_SRC_KIND_HI = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_SRC_INJECT = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_SRC_LOG = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_SRC_ENA = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_SRC_ENA_CLR = 12'h01c;
  localparam logic [ADDR_W-1:0] OFF_SRC_ENA_SET = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_SRC_ACTIVE = 12'h024;
  localparam logic [ADDR_W-1:0] OFF_TGT_MASK0 = 12'h028;
  localparam logic [ADDR_W-1:0] OFF_TGT_ACTIVE0 = 12'h038;
  localparam logic [ADDR_W-1:0] OFF_MOD_POL = 12'h048;
  localparam logic [ADDR_W-1:0] OFF_MOD_LEVEL = 12'h04c;
  localparam logic [ADDR_W-1:0] OFF_MOD_NONLATCH = 12'h050;
  localparam logic [ADDR_W-1:0] OFF_MOD_KIND = 12'h054;
  localparam logic [ADDR_W-1:0] OFF_MOD_LOG = 12'h058;
  localparam logic [ADDR_W-1:0] OFF_MOD_ENA = 12'h05c;
  localparam logic [ADDR_W-1:0] OFF_MOD_ACTIVE = 12'h060;
  localparam logic [ADDR_W-1:0] OFF_PIN_IN_POL = 12'h064;
  localparam logic [ADDR_W-1:0] OFF_PIN_OUT_POL = 12'h068;
  localparam logic [ADDR_W-1:0] OFF_PIN_DRV = 12'h06c;
  localparam logic [ADDR_W-1:0] DST_STRIDE = 12'h004;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
endpackage

/* File: tb/irq_router_checker.sv */
// Purpose: port-level assertions for the interrupt router
// Assumes: zero-wait apb, read data captured at the setup edge
// Notes: an enable shadow mirrors bus writes to judge outputs
`timescale 1ns/1ps
module irq_router_checker #(
  parameter int NUM_MOD = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb
  input irq_router_pkg::apb_req_s apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // sources
  input wire logic [irq_router_pkg::NUM_SRC-1:3] periph_irq,
  input wire logic [NUM_MOD-1:0] module_irq,
  input wire logic pin_source_zero,
  input wire logic pin_source_one,
  // destinations
  input wire logic [1:0] cpu_irq,
  input wire logic [1:0] pcie_irq_req,
  input wire logic [1:0] pin_irq_out,
  input wire logic [1:0] pin_irq_oe
);
  import irq_router_pkg::*;
  logic acc, wr_acc, rd_acc, setup;
  logic [23:0] ena_reg;
  // bus phase decode
  assign acc = apb_req.psel & apb_req.penable;
  assign wr_acc = acc & apb_req.pwrite;
  assign rd_acc = acc & ~apb_req.pwrite;
  assign setup = apb_req.psel & ~apb_req.penable;
  // enable shadow; aliases touch only the bits written as one
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ena_reg <= 24'h0;
    end else if (wr_acc && apb_req.paddr == OFF_SRC_ENA) begin
      ena_reg <= apb_req.pwdata[23:0];
    end else if (wr_acc && apb_req.paddr == OFF_SRC_ENA_CLR) begin
      ena_reg <= ena_reg & ~apb_req.pwdata[23:0];
    end else if (wr_acc && apb_req.paddr == OFF_SRC_ENA_SET) begin
      ena_reg <= ena_reg | apb_req.pwdata[23:0];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  ready_high_a: assert property (pready) else $error("pready low");
  err_phase_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
  err_map_a: assert property (acc && apb_req.paddr[1:0] == 2'h0
    |-> pslverr == (apb_req.paddr > 12'h06c)) else $error("pslverr wrong for address");
  data_holds_a: assert property (!setup |=> $stable(prdata)) else $error("prdata moved");
  raw_view_a: assert property (rd_acc && apb_req.paddr == OFF_SRC_LEVEL
    |-> prdata[23:3] == $past(periph_irq)) else $error("level view wrong");
  ena_view_a: assert property (rd_acc && apb_req.paddr == OFF_SRC_ENA
    |-> prdata == {8'h0, $past(ena_reg)}) else $error("enable readback wrong");
  inject_zero_a: assert property (rd_acc && apb_req.paddr == OFF_SRC_INJECT
    |-> prdata == 32'h0) else $error("inject reads nonzero");
  ena_quiet_a: assert property ((ena_reg == 24'h0) [*3]
    |-> cpu_irq == 2'h0 && pcie_irq_req == 2'h0) else $error("output with all disabled");
endmodule

/* File: tb/irq_src_model.sv */
// Purpose: far-side model of the interrupt source lines
// Assumes: sources change just after a clock edge
// Notes: lines hold their level, as level interrupt sources do
`timescale 1ns/1ps
module irq_src_model #(
  parameter int NUM_MOD = 4
) (
  // control
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [23:1] want_src,
  input wire logic [NUM_MOD-1:0] want_mod,
  // lines into the router
  output logic [23:3] periph_irq,
  output logic [NUM_MOD-1:0] module_irq,
  output logic pin_source_zero,
  output logic pin_source_one
);
  // all lines inactive low under reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {periph_irq, pin_source_one, pin_source_zero, module_irq} <= '0;
    end else begin
      {periph_irq, pin_source_one, pin_source_zero} <= want_src;
      module_irq <= want_mod;
    end
  end
endmodule

/* File: tb/irq_router_24src_4dst_bench.sv */
// Purpose: directed apb test of the interrupt router
// Assumes: zero-wait slave, sources driven by irq_src_model
// Notes: waits after stimulus cover pin sync and output flops
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module irq_router_24src_4dst_bench;
  import irq_router_pkg::*;
  localparam int NUM_MOD = 4;
  logic core_clk, reset_n, pready, pslverr, err, pin0, pin1;
  apb_req_s req;
  logic [31:0] prdata, rd;
  logic [23:3] periph_irq;
  logic [23:1] want_src;
  logic [NUM_MOD-1:0] module_irq, want_mod;
  logic [1:0] cpu_irq, pcie_irq_req, pin_irq_out, pin_irq_oe;
  int err_count = 0, samples_checked = 0, cycles = 0;
  irq_router_24src_4dst #(.NUM_MOD(NUM_MOD)) dut (.core_clk(core_clk), .reset_n(reset_n),
    .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_irq(periph_irq), .module_irq(module_irq), .pin_source_zero(pin0),
    .pin_source_one(pin1), .cpu_irq(cpu_irq), .pcie_irq_req(pcie_irq_req),
    .pin_irq_out(pin_irq_out), .pin_irq_oe(pin_irq_oe));
  irq_src_model #(.NUM_MOD(NUM_MOD)) model (.core_clk(core_clk), .reset_n(reset_n),
    .want_src(want_src), .want_mod(want_mod), .periph_irq(periph_irq),
    .module_irq(module_irq), .pin_source_zero(pin0), .pin_source_one(pin1));
  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // hang guard; the run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      end_sim();
    end
  end
  // one apb transfer, entered just after an edge; result taken at the ready edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    req <= '0;
    @(posedge core_clk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(err, 1'b0)
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    req = '0;
    reset_n = 1'b0;
    want_src = '0;
    want_mod = '0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rc(OFF_SRC_ENA, 32'h0);
    rc(12'(OFF_TGT_MASK0 + 3 * DST_STRIDE), 32'h0);
    xfer(1'b1, OFF_SRC_ENA_SET, 32'h9);
    xfer(1'b1, OFF_SRC_ENA_CLR, 32'h1);
    rc(OFF_SRC_ENA, 32'h8);
    $display("test enable aliases done");
    // each detect kind on source 3: rising step, then falling step
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, OFF_SRC_KIND_LO, 32'(k) << 6);
      xfer(1'b1, OFF_SRC_LOG, 32'hff_ffff);
      want_src[3] <= 1'b1;
      repeat (3) @(posedge core_clk);
      rc(OFF_SRC_LOG, (k != 2) ? 32'h8 : 32'h0);
      xfer(1'b1, OFF_SRC_LOG, 32'hff_ffff);
      want_src[3] <= 1'b0;
      repeat (3) @(posedge core_clk);
      rc(OFF_SRC_LOG, (k != 3) ? 32'h8 : 32'h0);
    end
    $display("test detect kinds done");
    xfer(1'b1, OFF_SRC_LOG, 32'hff_ffff);
    xfer(1'b1, OFF_SRC_INJECT, 32'h400);
    rc(OFF_SRC_LOG, 32'h400);
    rc(OFF_SRC_INJECT, 32'h0);
    $display("test inject done");
    // bypassed source 4 to cpu 0, latched source 6 to external 0
    xfer(1'b1, OFF_SRC_LOG, 32'hff_ffff);
    xfer(1'b1, OFF_SRC_NONLATCH, 32'h10);
    xfer(1'b1, OFF_SRC_ENA, 32'h50);
    xfer(1'b1, OFF_TGT_MASK0, 32'h10);
    xfer(1'b1, 12'(OFF_TGT_MASK0 + 2 * DST_STRIDE), 32'h40);
    want_src[6:4] <= 3'h5;
    repeat (4) @(posedge core_clk);
    `CHK({cpu_irq, pcie_irq_req}, 4'b0101)
    rc(OFF_SRC_ACTIVE, 32'h50);
    rc(12'(OFF_TGT_ACTIVE0 + 2 * DST_STRIDE), 32'h40);
    rc(OFF_SRC_LEVEL, 32'h50);
    want_src[4] <= 1'b0;
    repeat (4) @(posedge core_clk);
    `CHK(cpu_irq, 2'b00)
    $display("test routing done");
    // inverted permanent drive, then open collector
    // pin flops update at the edge that ends xfer, so look one edge later
    xfer(1'b1, OFF_PIN_OUT_POL, 32'h1);
    @(posedge core_clk);
    `CHK({pin_irq_oe, pin_irq_out}, 4'b1100)
    xfer(1'b1, OFF_PIN_DRV, 32'h3);
    @(posedge core_clk);
    `CHK({pin_irq_oe, pin_irq_out}, 4'b0110)
    $display("test pin outputs done");
    // module 0 feeds source 0, pin 0 lands on source 1
    xfer(1'b1, OFF_SRC_LOG, 32'hff_ffff);
    xfer(1'b1, OFF_MOD_ENA, 32'h1);
    want_mod <= 4'h1;
    want_src[1] <= 1'b1;
    repeat (5) @(posedge core_clk);
    rc(OFF_MOD_ACTIVE, 32'h1);
    rc(OFF_SRC_LOG, 32'h43);
    xfer(1'b1, OFF_MOD_POL, 32'h1);
    xfer(1'b1, OFF_MOD_LOG, 32'hf);
    rc(OFF_MOD_LOG, 32'h0);
    rc(OFF_MOD_LEVEL, 32'h0);
    // module bypass follows the corrected level and ignores the log
    xfer(1'b1, OFF_MOD_NONLATCH, 32'h1);
    want_mod <= 4'h0;
    repeat (3) @(posedge core_clk);
    rc(OFF_MOD_ACTIVE, 32'h1);
    want_mod <= 4'h1;
    repeat (3) @(posedge core_clk);
    rc(OFF_MOD_ACTIVE, 32'h0);
    // module falling-edge kind: corrected rise ignored, fall logged
    xfer(1'b1, OFF_MOD_NONLATCH, 32'h0);
    xfer(1'b1, OFF_MOD_KIND, 32'h2);
    xfer(1'b1, OFF_MOD_LOG, 32'hf);
    want_mod <= 4'h0;
    repeat (3) @(posedge core_clk);
    rc(OFF_MOD_LOG, 32'h0);
    want_mod <= 4'h1;
    repeat (3) @(posedge core_clk);
    rc(OFF_MOD_LOG, 32'h1);
    // inverted pin 1 reads active; high kind word keeps only its 16 bits
    xfer(1'b1, OFF_PIN_IN_POL, 32'h2);
    rc(OFF_SRC_LEVEL, 32'h47);
    xfer(1'b1, OFF_SRC_KIND_HI, 32'hffff_c000);
    rc(OFF_SRC_KIND_HI, 32'h0000_c000);
    xfer(1'b0, 12'h070, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("test modules and unmapped done");
    end_sim();
  end
endmodule
bind irq_router_24src_4dst irq_router_checker #(.NUM_MOD(NUM_MOD)) chk (.core_clk(core_clk),
  .reset_n(reset_n), .apb_req(apb_req), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .periph_irq(periph_irq), .module_irq(module_irq),
  .pin_source_zero(pin_source_zero), .pin_source_one(pin_source_one), .cpu_irq(cpu_irq),
  .pcie_irq_req(pcie_irq_req), .pin_irq_out(pin_irq_out), .pin_irq_oe(pin_irq_oe));
